// ==== inc/pcg_map.svh ====
// offsets, field positions and reset values of the peripheral clock gates
`ifndef PCG_MAP_SVH
`define PCG_MAP_SVH
`define PCG_ADDR_W          12
`define PCG_OFF_RUN_CFG     12'h060
`define PCG_OFF_RUN_GATE    12'h104
`define PCG_OFF_SLEEP_GATE  12'h114
`define PCG_OFF_DEEP_GATE   12'h124
`define PCG_ACG_BIT         27
`define PCG_GATE_RESET      32'h0000_0000
`define PCG_CFG_RESET       32'h0000_0000
`define PCG_GATE_MASK       32'h0107_1013
`define PCG_CFG_MASK        32'h0800_0000
`define PCG_BIT_ASYNC0      0
`define PCG_BIT_ASYNC1      1
`define PCG_BIT_SYNC0       4
`define PCG_BIT_TWOWIRE0    12
`define PCG_BIT_GP_TIMER_ZERO_GATE      16
`define PCG_BIT_GP_TIMER_ONE_GATE      17
`define PCG_BIT_GP_TIMER_TWO_GATE      18
`define PCG_BIT_COMPARATOR_ZERO_GATE       24
`define PCG_UNITS           8
`endif

// ==== inc/pcg_pkg.sv ====
// types shared by the peripheral clock gating block
package pcg_pkg;
   typedef enum logic [2:0] {
      PCG_PWR_RUN   = 3'b001,
      PCG_PWR_SLEEP = 3'b010,
      PCG_PWR_DEEP  = 3'b100
   } pcg_pwr_t;
   typedef logic [7:0] pcg_units_t;
endpackage

// ==== src/pcg_gate_cell.sv ====
// glitch-free clock gate for one peripheral
`timescale 1ns/1ps
`default_nettype none
module pcg_gate_cell (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic en,
   output var  logic en_lo_q,
   output wire logic gclk
);
   // enable moves on the falling edge, so it is stable while clk is high
   always_ff @(negedge clk or negedge rst_n) begin
      if (!rst_n) begin
         en_lo_q <= 1'b0;
      end else begin
         en_lo_q <= en;
      end
   end
   assign gclk = clk & en_lo_q;
endmodule
`default_nettype wire

// ==== src/pcg_top.sv ====
// peripheral clock gating group one with its apb register slave
//
// How it works
// RL1: set gate bit clocks its unit; clear bit stops its clock and disables it.
// RL2: access to an unclocked unit is answered with a bus fault.
// RL3: all gate bits reset to zero, all units start unclocked.
// RL4: three gate registers, same layout, for run, sleep and deep sleep.
// RL5: sleep and deep-sleep gates act only when auto gating is set.
// RL6: bit 16 gates timer zero, read and write.
// RL7: bit 17 gates timer one, read and write.
// RL8: bit 18 gates timer two, read and write.
// RL9: bit 12 gates two-wire module zero, read and write.
// RL10: bit 4 gates synchronous serial module zero, read and write.
// RL11: bits 1 and 0 gate asynchronous serial ports one and zero.
// RL12: all other gate bits are reserved, read only, read as zero.
// RL13: software keeps reserved bits unchanged in read-modify-write.
// RL14: software enables units before it touches them.
// RL15: bit 24 gates comparator zero, read and write.
// RL16: run gate rules unless auto gating picks sleep or deep-sleep gate.
// RL17: enables switch only while the gated clock is low.
`timescale 1ns/1ps
`default_nettype none
`include "pcg_map.svh"
module pcg_top
   import pcg_pkg::*;
(
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [`PCG_ADDR_W-1:0] paddr,
   input  wire logic [31:0]            pwdata,
   output var  logic [31:0]            prdata,
   output var  logic                   pready,
   output var  logic                   pslverr,
   input  wire logic                   sleep_req,
   input  wire logic                   deep_sleep_req,
   input  wire logic [7:0]             periph_sel,
   output var  logic [7:0]             unit_enable,
   output wire logic [7:0]             unit_clk,
   output var  logic                   bus_fault
);

   ////////////////////////////////////////////////////////////////////////
   // helpers

   // gather the eight unit bits of a gate word, unit order low to high
   function automatic pcg_units_t units_of(input logic [31:0] w);
      units_of = {w[`PCG_BIT_COMPARATOR_ZERO_GATE],   w[`PCG_BIT_GP_TIMER_TWO_GATE],
                  w[`PCG_BIT_GP_TIMER_ONE_GATE],  w[`PCG_BIT_GP_TIMER_ZERO_GATE],
                  w[`PCG_BIT_TWOWIRE0], w[`PCG_BIT_SYNC0],
                  w[`PCG_BIT_ASYNC1],  w[`PCG_BIT_ASYNC0]};
   endfunction

   function automatic logic is_mapped(input logic [`PCG_ADDR_W-1:0] a);
      is_mapped = (a == `PCG_OFF_RUN_CFG)    ||
                  (a == `PCG_OFF_RUN_GATE)   ||
                  (a == `PCG_OFF_SLEEP_GATE) ||
                  (a == `PCG_OFF_DEEP_GATE);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // apb slave, one access cycle, no wait states

   logic [31:0] run_gate_q;
   logic [31:0] sleep_gate_q;
   logic [31:0] deep_gate_q;
   logic [31:0] run_cfg_q;
   logic        pready_q;
   logic        pslverr_q;
   logic [31:0] prdata_q;
   logic        setup;
   logic        wr_en;
   logic [31:0] wr_gate_d;

   assign setup     = psel & ~penable;
   assign wr_en     = psel & penable & pwrite & pready_q & ~pslverr_q;
   assign wr_gate_d = pwdata & `PCG_GATE_MASK; // see RL12

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q  <= setup;
         pslverr_q <= setup & ~is_mapped(paddr);
      end
   end

   // reserved bits are never stored, so they read back as zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
      end else if (setup && !pwrite) begin
         case (paddr)
            `PCG_OFF_RUN_CFG:    prdata_q <= run_cfg_q;
            `PCG_OFF_RUN_GATE:   prdata_q <= run_gate_q;
            `PCG_OFF_SLEEP_GATE: prdata_q <= sleep_gate_q;
            `PCG_OFF_DEEP_GATE:  prdata_q <= deep_gate_q; // see RL12
            default:             prdata_q <= 32'h0000_0000;
         endcase
      end else if (!psel) begin
         prdata_q <= 32'h0000_0000;
      end
   end

   assign prdata  = prdata_q;
   assign pready  = pready_q;
   assign pslverr = pslverr_q;

   ////////////////////////////////////////////////////////////////////////
   // gate and configuration registers

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_gate_q <= `PCG_GATE_RESET; // see RL3
      end else if (wr_en && paddr == `PCG_OFF_RUN_GATE) begin
         run_gate_q <= wr_gate_d; // see RL4
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sleep_gate_q <= `PCG_GATE_RESET; // see RL3
      end else if (wr_en && paddr == `PCG_OFF_SLEEP_GATE) begin
         sleep_gate_q <= wr_gate_d; // see RL4
      end
   end

   // bits 0,1,4,12,16,17,18,24 each hold one unit's gate
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         deep_gate_q <= `PCG_GATE_RESET; // see RL3
      end else if (wr_en && paddr == `PCG_OFF_DEEP_GATE) begin
         deep_gate_q <= wr_gate_d; // see RL6 RL7 RL8 RL9 RL10 RL11 RL15
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_cfg_q <= `PCG_CFG_RESET;
      end else if (wr_en && paddr == `PCG_OFF_RUN_CFG) begin
         run_cfg_q <= pwdata & `PCG_CFG_MASK;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // power state from the core, pins pass two flops first

   logic [1:0] sleep_sync_q;
   logic [1:0] deep_sync_q;
   pcg_pwr_t   pwr;
   logic       auto_clock_gating_enable;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sleep_sync_q <= 2'b00;
         deep_sync_q  <= 2'b00;
      end else begin
         sleep_sync_q <= {sleep_sync_q[0], sleep_req};
         deep_sync_q  <= {deep_sync_q[0], deep_sleep_req};
      end
   end

   // deep sleep wins when both requests stand
   always_comb begin
      if (deep_sync_q[1]) begin
         pwr = PCG_PWR_DEEP;
      end else if (sleep_sync_q[1]) begin
         pwr = PCG_PWR_SLEEP;
      end else begin
         pwr = PCG_PWR_RUN;
      end
   end

   assign auto_clock_gating_enable = run_cfg_q[`PCG_ACG_BIT];

   ////////////////////////////////////////////////////////////////////////
   // effective enables

   pcg_units_t eff_d;
   pcg_units_t eff_en_q;

   always_comb begin
      eff_d = units_of(run_gate_q); // see RL16
      if (auto_clock_gating_enable) begin // see RL5
         case (pwr)
            PCG_PWR_RUN:   eff_d = units_of(run_gate_q);
            PCG_PWR_SLEEP: eff_d = units_of(sleep_gate_q); // see RL16
            PCG_PWR_DEEP:  eff_d = units_of(deep_gate_q); // see RL16
            default:       eff_d = units_of(run_gate_q);
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         eff_en_q <= '0; // see RL3
      end else begin
         eff_en_q <= eff_d; // see RL1
      end
   end

   assign unit_enable = eff_en_q; // see RL1

   ////////////////////////////////////////////////////////////////////////
   // per unit clock gates

   pcg_units_t gate_lo;

   // a low-phase enable costs half a cycle of latency but never clips a pulse
   for (genvar g = 0; g < `PCG_UNITS; g++) begin : g_gate
      pcg_gate_cell u_gate (
         .clk     (pclk),
         .rst_n   (presetn),
         .en      (eff_en_q[g]), // see RL17
         .en_lo_q (gate_lo[g]),
         .gclk    (unit_clk[g]) // see RL1
      );
   end

   ////////////////////////////////////////////////////////////////////////
   // bus fault for accesses to unclocked units

   logic bus_fault_q;

   // fabric holds periph_sel for its own access; software must enable first
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_fault_q <= 1'b0;
      end else begin
         bus_fault_q <= |(periph_sel & ~eff_en_q); // see RL2 RL14
      end
   end

   assign bus_fault = bus_fault_q;

   ////////////////////////////////////////////////////////////////////////
   // assertions

   property p_gate_clock_follows;
      @(posedge pclk) disable iff (!presetn)
      1'b1 |=> gate_lo == $past(eff_d);
   endproperty
   a_gate_clock_follows: assert property (p_gate_clock_follows) // see RL1
      else $error("gated clock enable does not follow unit enable");

   property p_fault_on_gated;
      @(posedge pclk) disable iff (!presetn)
      (|(periph_sel & ~eff_en_q)) |=> bus_fault;
   endproperty
   a_fault_on_gated: assert property (p_fault_on_gated) // see RL2
      else $error("access to unclocked unit gave no bus fault");

   property p_no_fault_on_clocked;
      @(posedge pclk) disable iff (!presetn)
      ((periph_sel & ~eff_en_q) == 8'h00) |=> !bus_fault;
   endproperty
   a_no_fault_on_clocked: assert property (p_no_fault_on_clocked) // see RL2
      else $error("bus fault raised for a clocked unit");

   property p_enable_needs_gate;
      @(posedge pclk) disable iff (!presetn)
      (unit_enable != 8'h00) |->
         ($past(run_gate_q | sleep_gate_q | deep_gate_q) != 32'h0000_0000);
   endproperty
   a_enable_needs_gate: assert property (p_enable_needs_gate) // see RL3
      else $error("unit enabled with all gate registers clear");

   property p_run_write_isolated;
      @(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == `PCG_OFF_RUN_GATE) |=>
         $stable(sleep_gate_q) && $stable(deep_gate_q);
   endproperty
   a_run_write_isolated: assert property (p_run_write_isolated) // see RL4
      else $error("run gate write disturbed another gate register");

   property p_run_rules_without_auto;
      @(posedge pclk) disable iff (!presetn)
      (!auto_clock_gating_enable && pwr != PCG_PWR_RUN) |=>
         eff_en_q == $past(units_of(run_gate_q));
   endproperty
   a_run_rules_without_auto: assert property (p_run_rules_without_auto) // see RL5
      else $error("sleep gate used while auto gating is off");

   property p_deep_select;
      @(posedge pclk) disable iff (!presetn)
      (auto_clock_gating_enable && pwr == PCG_PWR_DEEP) |=>
         eff_en_q == $past(units_of(deep_gate_q));
   endproperty
   a_deep_select: assert property (p_deep_select) // see RL16
      else $error("deep sleep gate not applied in deep sleep");

   property p_deep_write_store;
      @(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == `PCG_OFF_DEEP_GATE) |=>
         deep_gate_q == ($past(pwdata) & `PCG_GATE_MASK);
   endproperty
   a_deep_write_store: assert property (p_deep_write_store) // see RL6 RL7 RL8 RL9 RL10 RL11 RL15
      else $error("deep sleep gate write not stored at its unit bits");

   property p_reserved_zero;
      @(posedge pclk) disable iff (!presetn)
      pready ##0 !pwrite |->
         (prdata & ~(`PCG_GATE_MASK | `PCG_CFG_MASK)) == 32'h0000_0000;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) // see RL12
      else $error("reserved bits read non-zero");

   property p_lowphase_stable;
      @(posedge pclk) disable iff (!presetn)
      $changed(eff_en_q) |-> gate_lo == eff_en_q;
   endproperty
   a_lowphase_stable: assert property (p_lowphase_stable) // see RL17
      else $error("gate enable moved outside the low phase");

   c_deep_write: cover property (@(posedge pclk) disable iff (!presetn)
      wr_en && paddr == `PCG_OFF_DEEP_GATE);
   c_fault: cover property (@(posedge pclk) disable iff (!presetn)
      bus_fault);
   c_deep_auto: cover property (@(posedge pclk) disable iff (!presetn)
      auto_clock_gating_enable && pwr == PCG_PWR_DEEP && eff_en_q != 8'h00);
   c_unmapped: cover property (@(posedge pclk) disable iff (!presetn)
      pready && pslverr);

endmodule
`default_nettype wire

// ==== tb/pcg_fabric_model.sv ====
// far side: gated units that count their clock pulses, fabric select lines
`timescale 1ns/1ps
`default_nettype none
module pcg_fabric_model (
   input  wire logic        presetn,
   input  wire logic [7:0]  unit_clk,
   input  wire logic        acc_v,
   input  wire logic [2:0]  acc_u,
   output var  logic [7:0]  periph_sel,
   output var  logic [15:0] pulse_cnt [8]
);
   // fabric decodes one unit per access, so the select is one hot
   always_comb periph_sel = acc_v ? (8'h01 << acc_u) : 8'h00;
   for (genvar i = 0; i < 8; i++) begin : g_unit
      // a runt pulse would count too, so glitches show up as extra pulses
      always @(posedge unit_clk[i] or negedge presetn) begin
         if (!presetn)
            pulse_cnt[i] <= 16'h0000;
         else
            pulse_cnt[i] <= pulse_cnt[i] + 16'h0001;
      end
   end
endmodule
`default_nettype wire

// ==== tb/pcg_top_test.sv ====
// self-checking bench for peripheral clock gating group one
`timescale 1ns/1ps
`default_nettype none
`include "pcg_map.svh"
module pcg_top_test;
   localparam int ubit [8] = '{0, 1, 4, 12, 16, 17, 18, 24};
   logic        pclk, presetn, psel, penable, pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic        pready, pslverr, sleep_req, deep_sleep_req, bus_fault;
   logic [7:0]  periph_sel, unit_enable, unit_clk;
   logic        acc_v;
   logic [2:0]  acc_u;
   logic [15:0] pulse_cnt [8];
   logic [11:0] goff [3] = '{`PCG_OFF_RUN_GATE, `PCG_OFF_SLEEP_GATE,
                             `PCG_OFF_DEEP_GATE};
   int          error_cnt = 0;
   int          checks = 0;

   pcg_top u_pcg_top (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sleep_req(sleep_req), .deep_sleep_req(deep_sleep_req),
      .periph_sel(periph_sel), .unit_enable(unit_enable),
      .unit_clk(unit_clk), .bus_fault(bus_fault));
   pcg_fabric_model u_pcg_fabric_model (.presetn(presetn),
      .unit_clk(unit_clk), .acc_v(acc_v), .acc_u(acc_u),
      .periph_sel(periph_sel), .pulse_cnt(pulse_cnt));

   ////////////////////////////////////////////////////////////////////////
   task automatic conclude();
      if (error_cnt == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, got);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   function automatic logic [7:0] units(input logic [31:0] v);
      for (int i = 0; i < 8; i++)
         units[i] = v[ubit[i]];
   endfunction
   function automatic logic [31:0] legal(input logic [31:0] v);
      legal = 32'h0;
      for (int i = 0; i < 8; i++)
         legal[ubit[i]] = v[ubit[i]];
   endfunction
   // entered at a rising edge; lets one edge pass so psel is never
   // driven twice in one step between back-to-back calls
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic er);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      // waits as long as the slave needs; only the watchdog ends a hang
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rc(input string nm, input logic [11:0] a,
                     input logic [31:0] exp, input logic ee);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      chk(nm, exp, r);
      chk("pslverr", {31'h0, ee}, {31'h0, e});
   endtask
   // pulses sampled on the falling edge, away from the counting edge
   task automatic en_chk(input string nm, input logic [7:0] exp);
      logic [15:0] c0 [8];
      repeat (5) @(posedge pclk);
      chk(nm, {24'h0, exp}, {24'h0, unit_enable});
      @(negedge pclk);
      c0 = pulse_cnt;
      repeat (20) @(negedge pclk);
      for (int i = 0; i < 8; i++)
         chk("pulses", exp[i] ? 32'h14 : 32'h0, {16'h0, pulse_cnt[i] - c0[i]});
      @(posedge pclk);
   endtask
   task automatic fault_chk(input logic [7:0] en);
      for (int i = 0; i < 8; i++) begin
         acc_v <= 1'b1;
         acc_u <= 3'(i);
         @(posedge pclk);
         @(negedge pclk);
         chk("bus_fault", {31'h0, !en[i]}, {31'h0, bus_fault});
         @(posedge pclk);
      end
      acc_v <= 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   initial begin
      repeat (20000) @(posedge pclk);
      error_cnt++;
      conclude();
   end
   initial begin
      logic [31:0] v, s, d;
      logic        e;
      {presetn, psel, penable, pwrite, sleep_req, deep_sleep_req} = 6'h00;
      {paddr, pwdata, acc_v, acc_u} = 48'h0;
      void'($urandom(20));
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      chk("unit_enable", 32'h0, {24'h0, unit_enable});
      for (int k = 0; k < 3; k++)
         rc("gate reset", goff[k], 32'h0, 1'b0);
      rc("cfg reset", `PCG_OFF_RUN_CFG, 32'h0, 1'b0);
      rc("unmapped", 12'h200, 32'h0, 1'b1);
      // first pass all ones: reserved bits must read back zero
      for (int j = 0; j < 12; j++) begin
         v = (j < 3) ? 32'hffff_ffff : $urandom;
         wr(goff[j % 3], v);
         rc("gate", goff[j % 3], legal(v), 1'b0);
      end
      for (int j = 0; j < 4; j++) begin
         v = (j == 0) ? 32'h0 : $urandom;
         wr(`PCG_OFF_RUN_GATE, v);
         en_chk("run enable", units(v));
         fault_chk(units(v));
      end
      apb(1'b0, `PCG_OFF_RUN_GATE, 32'h0, s, e);
      wr(`PCG_OFF_RUN_GATE, s | 32'h0001_0000);
      en_chk("rmw", units(s) | 8'h10);
      s = $urandom;
      d = $urandom;
      v = $urandom;
      wr(`PCG_OFF_SLEEP_GATE, s);
      wr(`PCG_OFF_DEEP_GATE, d);
      wr(`PCG_OFF_RUN_GATE, v);
      sleep_req <= 1'b1;
      en_chk("sleep no auto", units(v));
      wr(`PCG_OFF_RUN_CFG, 32'hffff_ffff);
      rc("cfg", `PCG_OFF_RUN_CFG, 32'h0800_0000, 1'b0);
      en_chk("sleep auto", units(s));
      deep_sleep_req <= 1'b1;
      en_chk("deep auto", units(d));
      sleep_req <= 1'b0;
      deep_sleep_req <= 1'b0;
      en_chk("run auto", units(v));
      conclude();
   end
endmodule
`default_nettype wire
